// ==== tbdg_cfg.svh ====
/*
  Constants for the line diagnostic status registers: register offsets,
  field positions, reset values, reporting limits and the skew refresh timing.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef TBDG_CFG_SVH
`define TBDG_CFG_SVH

// register offsets inside management device 1
`define TBDG_REG_RX_POWER_C     16'h008f
`define TBDG_REG_RX_POWER_D     16'h0090
`define TBDG_REG_SKEW_PART0     16'h0091
`define TBDG_REG_SKEW_PART1     16'h0092

// register and field widths
`define TBDG_REG_W              16
`define TBDG_SKEW_W             7
`define TBDG_PWR_IN_W           16
`define TBDG_SKEW_IN_W          10

// skew field positions
`define TBDG_SKEW_HI_LSB        8
`define TBDG_SKEW_LO_LSB        0

// reset values
`define TBDG_PWR_RESET          16'h8000
`define TBDG_SKEW_RESET         7'h00

// receive power limits, in tenths of a dBm
`define TBDG_PWR_MIN_X10        (-16'sd200)
`define TBDG_PWR_MAX_X10        (16'sd55)

// skew field limits, in 1.25 ns steps (-80 ns and +78.75 ns)
`define TBDG_SKEW_MIN_CODE      7'h40
`define TBDG_SKEW_MAX_CODE      7'h3f

// skew refresh timing
`define TBDG_CLK_HZ             40000000
`define TBDG_SKEW_REFRESH_S     1
`define TBDG_SKEW_REFRESH_CYC   (`TBDG_SKEW_REFRESH_S * `TBDG_CLK_HZ)

`endif

// ==== tbdg_line_diag_regs.sv ====
/*
  Read-only line diagnostic status registers: receive power of pairs c and d
  and the skew of pairs b, c and d against pair a.
  Assumes a management frame decoder in front that presents a register
  address with one-cycle read and write strobes, and training logic that
  delivers power samples and a running skew measurement on clk_sys.
*/
// What this block does
// - one read-only 16-bit receive power register each for pairs c and d
// - power in 0.1 dB steps, offset two's complement, 0x8000 is 0 dB, also reset
// - reported receive power spans -20 dBm up to 5.5 dBm
// - skew b in part0 14:8; skew d in part1 14:8, c in 6:0
// - skew fields are 7-bit two's complement, 1.25 ns step, positive means delayed
// - skew beyond -80..+78.75 ns saturates at the extreme code, never wraps
// - each skew field refreshes at least once per second while measuring
`timescale 1ns/1ps
`include "tbdg_cfg.svh"

module tbdg_line_diag_regs #(
	parameter int unsigned REFRESH_CYCLES = `TBDG_SKEW_REFRESH_CYC
) (
	input  wire logic                         clk_sys,
	input  wire logic                         srst,
	input  wire tbdg_pkg::tbdg_pwr_meas_t     pwr_meas,
	input  wire tbdg_pkg::tbdg_skew_meas_t    skew_meas,
	input  wire logic [`TBDG_REG_W-1:0]       reg_addr,
	input  wire logic                         reg_rd,
	input  wire logic                         reg_wr,
	output logic [`TBDG_REG_W-1:0]            reg_rdata,
	output logic                              reg_rvalid,
	output logic                              reg_hit,
	output logic                              reg_wr_ignored
);
	import tbdg_pkg::*;

	// a one second period at the core rate needs a wide counter, so size it from the period
	localparam int unsigned CNT_W  = (REFRESH_CYCLES > 1) ? $clog2(REFRESH_CYCLES) : 1;
	localparam int unsigned NPAIRS = 3;

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYCLES - 1);

	// clamp a power sample into the reportable span and encode it
	function automatic logic [`TBDG_REG_W-1:0] pwr_encode(
		input logic signed [`TBDG_PWR_IN_W-1:0] sample
	);
		logic signed [`TBDG_PWR_IN_W-1:0] clamped;
		clamped = sample;
		// clamping keeps a wild sample from wrapping into a plausible-looking code
		if (sample < `TBDG_PWR_MIN_X10) begin
			clamped = `TBDG_PWR_MIN_X10;
		end else if (sample > `TBDG_PWR_MAX_X10) begin
			clamped = `TBDG_PWR_MAX_X10;
		end
		// adding 0x8000 to a 16-bit two's complement value is an msb flip
		pwr_encode = {~clamped[15], clamped[14:0]};
	endfunction : pwr_encode

	// receive power registers
	logic [`TBDG_REG_W-1:0] pwr_c_q;
	logic [`TBDG_REG_W-1:0] pwr_c_d;
	logic [`TBDG_REG_W-1:0] pwr_d_q;
	logic [`TBDG_REG_W-1:0] pwr_d_d;

	// only training samples and reset move these; management writes never do
	always_comb begin
		pwr_c_d = pwr_c_q;
		pwr_d_d = pwr_d_q;
		if (pwr_meas.valid) begin
			pwr_c_d = pwr_encode(pwr_meas.pair_c);
			pwr_d_d = pwr_encode(pwr_meas.pair_d);
		end
	end

	// power registers; reset loads the 0 dB code
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pwr_c_q <= `TBDG_PWR_RESET;
			pwr_d_q <= `TBDG_PWR_RESET;
		end else begin
			pwr_c_q <= pwr_c_d;
			pwr_d_q <= pwr_d_d;
		end
	end

	// skew refresh timer
	logic [CNT_W-1:0] refresh_cnt_q;
	logic [CNT_W-1:0] refresh_cnt_d;
	logic             refresh_tick;
	logic             skew_capture;

	// a forced capture at the period end bounds the age of every skew field
	assign refresh_tick = skew_meas.active && (refresh_cnt_q == CNT_LAST);
	assign skew_capture = skew_meas.active && (skew_meas.update || refresh_tick);

	// counter idles at zero while measuring is off, so the first forced capture
	// comes one full period after the measurement starts
	always_comb begin
		refresh_cnt_d = refresh_cnt_q + CNT_W'(1);
		if (!skew_meas.active || skew_capture) begin
			refresh_cnt_d = '0;
		end
	end

	// refresh counter register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			refresh_cnt_q <= '0;
		end else begin
			refresh_cnt_q <= refresh_cnt_d;
		end
	end

	// skew fields, one saturating converter and one register per pair
	logic signed [`TBDG_SKEW_IN_W-1:0] skew_raw [NPAIRS];
	tbdg_skew_code_t                   skew_sat [NPAIRS];
	tbdg_skew_code_t                   skew_q   [NPAIRS];
	tbdg_skew_code_t                   skew_d   [NPAIRS];

	// array index 0 is pair b, 1 is pair c, 2 is pair d
	assign skew_raw[0] = skew_meas.pair_b;
	assign skew_raw[1] = skew_meas.pair_c;
	assign skew_raw[2] = skew_meas.pair_d;

	for (genvar p = 0; p < NPAIRS; p++) begin : g_pair
		tbdg_skew_sat #(
			.IN_W      (`TBDG_SKEW_IN_W)
		) u_sat (
			.skew_in   (skew_raw[p]),
			.skew_code (skew_sat[p])
		);

		// all three fields move together so a read sees one measurement
		always_comb begin
			skew_d[p] = skew_q[p];
			if (skew_capture) begin
				skew_d[p] = skew_sat[p];
			end
		end

		// skew field register for this pair
		always_ff @(posedge clk_sys) begin
			if (srst) begin
				skew_q[p] <= `TBDG_SKEW_RESET;
			end else begin
				skew_q[p] <= skew_d[p];
			end
		end
	end

	// register read mux; reserved bits return zero, software ignores them
	logic [`TBDG_REG_W-1:0] rd_mux;
	logic                   rd_hit;

	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (reg_addr)
			`TBDG_REG_RX_POWER_C: begin
				rd_mux = pwr_c_q;
			end
			`TBDG_REG_RX_POWER_D: begin
				rd_mux = pwr_d_q;
			end
			`TBDG_REG_SKEW_PART0: begin
				rd_mux[`TBDG_SKEW_HI_LSB +: `TBDG_SKEW_W] = skew_q[0];
			end
			`TBDG_REG_SKEW_PART1: begin
				rd_mux[`TBDG_SKEW_HI_LSB +: `TBDG_SKEW_W] = skew_q[2];
				rd_mux[`TBDG_SKEW_LO_LSB +: `TBDG_SKEW_W] = skew_q[1];
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// read answer and write refusal, registered one cycle after the strobe
	logic [`TBDG_REG_W-1:0] rdata_q;
	logic [`TBDG_REG_W-1:0] rdata_d;
	logic                   rvalid_q;
	logic                   rvalid_d;
	logic                   hit_q;
	logic                   hit_d;
	logic                   wr_ign_q;
	logic                   wr_ign_d;

	// data holds between reads so a slow frame decoder may sample late
	always_comb begin
		rdata_d  = rdata_q;
		hit_d    = hit_q;
		rvalid_d = reg_rd;
		wr_ign_d = reg_wr && rd_hit;
		if (reg_rd) begin
			rdata_d = rd_mux;
			hit_d   = rd_hit;
		end
	end

	// answer registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
			hit_q    <= 1'b0;
			wr_ign_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			hit_q    <= hit_d;
			wr_ign_q <= wr_ign_d;
		end
	end

	// every output comes straight from a flip-flop
	assign reg_rdata      = rdata_q;
	assign reg_rvalid     = rvalid_q;
	assign reg_hit        = hit_q;
	assign reg_wr_ignored = wr_ign_q;

endmodule : tbdg_line_diag_regs

// ==== tbdg_mgmt_model.sv ====
/* management station model: register reads and writes
   assumes one-cycle strobes answered one cycle later */
`timescale 1ns/1ps
module tbdg_mgmt_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	input  wire logic        reg_hit,
	input  wire logic        reg_wr_ignored,
	output logic      [15:0] reg_addr,
	output logic             reg_rd,
	output logic             reg_wr
);
	// idle bus at time zero
	initial begin
		reg_addr = 16'hffff;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
	end
	// answer taken at the edge that sees rvalid; address scrambled once released
	task automatic rd(input logic [15:0] a, output logic [17:0] r);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		r = {reg_rvalid, reg_hit, reg_rdata};
		if (a == 16'h0091) r[15:0] &= 16'h7f00;
		if (a == 16'h0092) r[15:0] &= 16'h7f7f;
	endtask : rd
	// second edge waits for the registered ack before reg_wr_ignored is taken
	task automatic wr(input logic [15:0] a, output logic ack);
		reg_addr <= a;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		ack = reg_wr_ignored;
	endtask : wr
endmodule : tbdg_mgmt_model

// ==== tbdg_pkg.sv ====
/*
  Types for the line diagnostic status registers.
  Assumes tbdg_cfg.svh is on the include path.
*/
`include "tbdg_cfg.svh"

package tbdg_pkg;

	// receive power samples from training, tenths of a dBm, signed
	typedef struct packed {
		logic                                valid;
		logic signed [`TBDG_PWR_IN_W-1:0]    pair_c;
		logic signed [`TBDG_PWR_IN_W-1:0]    pair_d;
	} tbdg_pwr_meas_t;

	// current skew of pairs b, c, d against pair a, 1.25 ns steps, signed
	typedef struct packed {
		logic                                active;
		logic                                update;
		logic signed [`TBDG_SKEW_IN_W-1:0]   pair_b;
		logic signed [`TBDG_SKEW_IN_W-1:0]   pair_c;
		logic signed [`TBDG_SKEW_IN_W-1:0]   pair_d;
	} tbdg_skew_meas_t;

	typedef logic [`TBDG_SKEW_W-1:0] tbdg_skew_code_t;

endpackage : tbdg_pkg

// ==== tbdg_regs_checker.sv ====
/* assertions on the status register block's ports
   assumes it is bound into tbdg_line_diag_regs */
`timescale 1ns/1ps
`include "tbdg_cfg.svh"
module tbdg_regs_checker #(
	parameter int unsigned REFRESH_CYCLES = 16
) (
	input wire logic                    clk_sys,
	input wire logic                    srst,
	input wire tbdg_pkg::tbdg_pwr_meas_t  pwr_meas,
	input wire tbdg_pkg::tbdg_skew_meas_t skew_meas,
	input wire logic [15:0]             reg_addr,
	input wire logic                    reg_rd,
	input wire logic                    reg_wr,
	input wire logic [15:0]             reg_rdata,
	input wire logic                    reg_rvalid,
	input wire logic                    reg_hit,
	input wire logic                    reg_wr_ignored
);
	import tbdg_pkg::*;
	logic mapped;
	// the four status words sit back to back
	assign mapped = reg_addr inside {[16'h008f:16'h0092]};
	// helper for the refresh check: cycles that pair b has stood still while measuring
	logic signed [9:0] prev_b_q;
	logic [31:0]       calm_q;
	logic [6:0]        sat_b;
	assign sat_b = ($signed(skew_meas.pair_b) > 10'sd63) ? 7'h3f :
		(($signed(skew_meas.pair_b) < -10'sd64) ? 7'h40 : skew_meas.pair_b[6:0]);
	always_ff @(posedge clk_sys) begin
		prev_b_q <= skew_meas.pair_b;
		if (srst || !skew_meas.active || skew_meas.pair_b != prev_b_q) begin
			calm_q <= '0;
		end else if (calm_q < REFRESH_CYCLES) begin
			calm_q <= calm_q + 32'd1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// read answers and write acknowledges, one cycle late
	chk_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
	chk_wr_ack: assert property (reg_wr && mapped |=> reg_wr_ignored) else $error("no ack");
	chk_ack_cause: assert property (reg_wr_ignored |-> $past(reg_wr)) else $error("stray ack");
	chk_hit_flag: assert property (reg_rd |=> reg_hit == $past(mapped)) else $error("bad hit");
	chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
		else $error("unmapped data");
	chk_pwr_span: assert property (reg_rd && reg_addr inside {16'h008f, 16'h0090}
		|=> reg_rdata inside {[16'h7f38:16'h8037]}) else $error("power out of span");
	chk_rsvd_bits: assert property (reg_rd && reg_addr inside {16'h0091, 16'h0092}
		|=> reg_rdata[15] == 1'b0) else $error("skew bit 15 set");
	chk_pwr_zero: assert property (pwr_meas.valid && pwr_meas.pair_c == '0
		##1 reg_rd && reg_addr == 16'h008f |=> reg_rdata == 16'h8000) else $error("zero dB");
	chk_skew_sat: assert property (skew_meas.active && skew_meas.update
		&& skew_meas.pair_b > 10'sd63 ##1 reg_rd && reg_addr == 16'h0091
		|=> reg_rdata[14:8] == 7'h3f) else $error("skew not saturated");
	chk_skew_refresh: assert property (reg_rd && reg_addr == 16'h0091 && calm_q >= REFRESH_CYCLES
		|=> reg_rdata[14:8] == $past(sat_b)) else $error("skew not refreshed");
endmodule : tbdg_regs_checker
bind tbdg_line_diag_regs tbdg_regs_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) chk (
	.clk_sys, .srst, .pwr_meas, .skew_meas, .reg_addr, .reg_rd, .reg_wr,
	.reg_rdata, .reg_rvalid, .reg_hit, .reg_wr_ignored);

// ==== tbdg_skew_sat.sv ====
/*
  Saturating converter from a wide signed skew measurement to the 7-bit
  two's complement skew field.
  Assumes the input is already in 1.25 ns steps; purely combinational.
*/
`timescale 1ns/1ps
`include "tbdg_cfg.svh"

module tbdg_skew_sat #(
	parameter int unsigned IN_W = `TBDG_SKEW_IN_W
) (
	input  wire logic signed [IN_W-1:0]  skew_in,
	output tbdg_pkg::tbdg_skew_code_t    skew_code
);
	import tbdg_pkg::*;

	localparam logic signed [IN_W-1:0] MAX_IN = IN_W'(63);
	localparam logic signed [IN_W-1:0] MIN_IN = -IN_W'(64);

	// clamp instead of wrapping when the skew leaves -80..+78.75 ns
	always_comb begin
		if (skew_in > MAX_IN) begin
			skew_code = `TBDG_SKEW_MAX_CODE;
		end else if (skew_in < MIN_IN) begin
			skew_code = `TBDG_SKEW_MIN_CODE;
		end else begin
			skew_code = skew_in[`TBDG_SKEW_W-1:0];
		end
	end

endmodule : tbdg_skew_sat

// ==== testbench.sv ====
/* self-checking bench for the status registers
   assumes the checker is bound in; 40 MHz clock */
`timescale 1ns/1ps
module testbench;
	import tbdg_pkg::*;
	localparam int unsigned REFRESH = 16;
	logic            clk_sys = 1'b0;
	logic            srst = 1'b1;
	tbdg_pwr_meas_t  pwr_meas = '0;
	tbdg_skew_meas_t skew_meas = '0;
	logic [15:0]     reg_addr, reg_rdata;
	logic            reg_rd, reg_wr, reg_rvalid, reg_hit, reg_wr_ignored;
	logic [17:0]     r;
	int              n_errors = 0;
	int              cmp_count = 0;
	always #12.5 clk_sys = ~clk_sys;
	tbdg_line_diag_regs #(.REFRESH_CYCLES(REFRESH)) uut (.clk_sys, .srst, .pwr_meas,
		.skew_meas, .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_rvalid, .reg_hit,
		.reg_wr_ignored);
	tbdg_mgmt_model mgr (.clk_sys, .reg_rdata, .reg_rvalid, .reg_hit, .reg_wr_ignored,
		.reg_addr, .reg_rd, .reg_wr);
	// clamp keeps the expectation inside the reportable span
	function automatic logic [15:0] pwr_code(int v);
		return 16'h8000 + 16'(v < -200 ? -200 : (v > 55 ? 55 : v));
	endfunction : pwr_code
	function automatic logic [6:0] sk(int v);
		return 7'(v < -64 ? -64 : (v > 63 ? 63 : v));
	endfunction : sk
	task automatic rc(string n, logic [15:0] a, logic h, logic [15:0] d);
		mgr.rd(a, r);
		cmp_count++;
		if (r !== {1'b1, h, d}) begin
			n_errors++;
			$display("ERROR %s expected %h got %h", n, {1'b1, h, d}, r);
		end
	endtask : rc
	task automatic wc(string n, logic [15:0] a, logic e);
		logic k;
		mgr.wr(a, k);
		cmp_count++;
		if (k !== e) begin
			n_errors++;
			$display("ERROR %s expected %b got %b", n, e, k);
		end
	endtask : wc
	task automatic skew_in(logic act, logic up, int b, int c, int d);
		skew_meas <= '{act, up, 10'(b), 10'(c), 10'(d)};
		@(posedge clk_sys);
		skew_meas.update <= 1'b0;
	endtask : skew_in
	task automatic skew_rd(string n, int b, int c, int d);
		rc(n, 16'h0091, 1'b1, {1'b0, sk(b), 8'h00});
		rc(n, 16'h0092, 1'b1, {1'b0, sk(d), 1'b0, sk(c)});
	endtask : skew_rd
	task automatic t_reset;
		rc("pwr_c", 16'h008f, 1'b1, 16'h8000);
		rc("pwr_d", 16'h0090, 1'b1, 16'h8000);
		skew_rd("skew_rst", 0, 0, 0);
		rc("unmapped", 16'h0093, 1'b0, 16'h0000);
		$display("reset test done");
	endtask : t_reset
	task automatic t_power;
		int v[6] = '{-30, 0, -200, 55, -300, 100};
		foreach (v[i]) begin
			pwr_meas <= '{1'b1, 16'(v[i]), 16'(-v[i])};
			@(posedge clk_sys);
			pwr_meas.valid <= 1'b0;
			rc("pwr_c", 16'h008f, 1'b1, pwr_code(v[i]));
			rc("pwr_d", 16'h0090, 1'b1, pwr_code(-v[i]));
		end
		wc("wr_ack", 16'h008f, 1'b1);
		wc("wr_unmapped", 16'h0093, 1'b0);
		rc("pwr_ro", 16'h008f, 1'b1, pwr_code(100));
		$display("power test done");
	endtask : t_power
	task automatic t_rerun_reset;
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rc("pwr_c_rst", 16'h008f, 1'b1, 16'h8000);
		rc("pwr_d_rst", 16'h0090, 1'b1, 16'h8000);
		$display("mid-run reset test done");
	endtask : t_rerun_reset
	task automatic t_skew;
		int t[3][3] = '{'{100, -100, -5}, '{63, -64, 1}, '{511, -512, -65}};
		foreach (t[i]) begin
			skew_in(1'b1, 1'b1, t[i][0], t[i][1], t[i][2]);
			skew_rd("skew", t[i][0], t[i][1], t[i][2]);
		end
		$display("skew test done");
	endtask : t_skew
	task automatic t_refresh;
		skew_in(1'b1, 1'b0, 7, -7, 20);
		repeat (REFRESH + 2) @(posedge clk_sys);
		skew_rd("refresh", 7, -7, 20);
		skew_in(1'b0, 1'b1, 30, 30, 30);
		repeat (REFRESH + 2) @(posedge clk_sys);
		skew_rd("inactive", 7, -7, 20);
		$display("refresh test done");
	endtask : t_refresh
	task automatic test_done;
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	// main sequence after six reset cycles
	initial begin
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_power();
		t_rerun_reset();
		t_skew();
		t_refresh();
		test_done();
	end
	// whole run needs about 120 cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end
endmodule : testbench
